// File: rtl/tie_defines.vh
// Contract
// - string_output copies elements from an incrementing address_reg_zero source to a fixed address_reg_one destination, counted by count_reg_three.
// - string_store writes gen_reg_zero_low_byte or gen_reg_zero_word to an incrementing address_reg_one destination, counted by count_reg_three.
// - store_if_nonzero copies source to destination only while the zero flag is clear, else leaves it alone.
// - store_if_zero copies source to destination only while the zero flag is set, else leaves it alone.
// - store_selected_by_zero always writes, taking the first source when zero is one and the second when zero is zero.
// - exchange_operands swaps the two operands so each ends with the other's old value.
// - a short_immediate is an 8-bit signed value in the range -128 to +127.
// - a control operand naming the stack pointer reaches the stack pointer chosen by the stack-select flag.
// - the control restore form changes the flags only when condition_flags_register is its destination.
// - marked forms use gen_reg_zero_low_byte as their only register-direct operand.
// - a selectable byte register is only the low or high byte of general register zero or one.
// - indirect addressing works for every operand except data registers, stack pointer, stack-relative and immediate.
// - sized transfers support byte and word widths chosen by the size bit.
`ifndef TIE_DEFINES_VH
`define TIE_DEFINES_VH

// register byte offsets
`define TIE_OFF_CMD 12'h000
`define TIE_OFF_STATUS 12'h004
`define TIE_OFF_GR0 12'h008
`define TIE_OFF_GR1 12'h00C
`define TIE_OFF_CNT3 12'h010
`define TIE_OFF_ADR0 12'h014
`define TIE_OFF_ADR1 12'h018
`define TIE_OFF_FLAGS 12'h01C
`define TIE_OFF_USP 12'h020
`define TIE_OFF_ISP 12'h024
`define TIE_OFF_MADDR 12'h028
`define TIE_OFF_MDATA 12'h02C
`define TIE_OFF_SBASE 12'h030
`define TIE_OFF_LAST 12'h030

// command word fields
`define TIE_CMD_OP 3:0
`define TIE_CMD_SIZE 4
`define TIE_CMD_SRC 7:5
`define TIE_CMD_DST 10:8
`define TIE_CMD_SRC2 13:11
`define TIE_CMD_IMPL 14
`define TIE_CMD_IMM 23:16

// opcodes
`define TIE_OP_STRING_OUTPUT 4'h1
`define TIE_OP_STRING_STORE 4'h2
`define TIE_OP_STORE_IF_NONZERO 4'h3
`define TIE_OP_STORE_IF_ZERO 4'h4
`define TIE_OP_STORE_SEL_ZERO 4'h5
`define TIE_OP_EXCHANGE 4'h6
`define TIE_OP_RESTORE_CTRL 4'h7

// operand selector codes
`define TIE_SEL_R0 3'h0
`define TIE_SEL_R1 3'h1
`define TIE_SEL_R0H_R3 3'h2
`define TIE_SEL_R1H_A0 3'h3
`define TIE_SEL_IND_A0 3'h4
`define TIE_SEL_IND_A1 3'h5
`define TIE_SEL_IMM 3'h6
`define TIE_SEL_SP 3'h7

// control restore targets
`define TIE_CTL_FLAGS 3'h0
`define TIE_CTL_SP 3'h1
`define TIE_CTL_SBASE 3'h2

// flag bit positions
`define TIE_FLG_C 0
`define TIE_FLG_D 1
`define TIE_FLG_Z 2
`define TIE_FLG_S 3
`define TIE_FLG_B 4
`define TIE_FLG_O 5
`define TIE_FLG_I 6
`define TIE_FLG_U 7

// status bits
`define TIE_ST_BUSY 0
`define TIE_ST_ERR 1
`define TIE_ST_STORED 2

// reset values
`define TIE_RST_WORD 16'h0000
`define TIE_RST_FLAGS 8'h00
`define TIE_RST_CMD 32'h00000000

// address steps
`define TIE_STEP_BYTE 16'h0001
`define TIE_STEP_WORD 16'h0002

`endif

// File: rtl/tie_apb_if.v
`timescale 1ns/1ps
`include "tie_defines.vh"

module tie_apb_if (
   input wire psel, // slave select
   input wire penable, // access phase
   input wire pwrite, // direction
   input wire [11:0] paddr, // byte address
   output wire pready, // always ready
   output wire pslverr, // unmapped access
   output wire wr_en, // write takes effect
   output wire rd_setup, // read setup cycle
   output wire [11:0] reg_addr // word-aligned address
);
   wire mapped;

   // zero wait states keep the master simple
   assign pready = 1'b1;
   assign mapped = (paddr[1:0] == 2'h0) && (paddr <= `TIE_OFF_LAST);
   assign pslverr = psel & penable & ~mapped;
   assign wr_en = psel & penable & pwrite & mapped;
   // read data is caught at setup so prdata comes from a flop
   assign rd_setup = psel & ~penable & ~pwrite;
   // unmapped reads land on an unused slot, so prdata comes back zero
   assign reg_addr = mapped ? paddr : 12'hFFC;
endmodule // tie_apb_if

// File: rtl/tie_operand.v
`timescale 1ns/1ps
`include "tie_defines.vh"

module tie_operand (
   input wire [2:0] sel, // operand selector
   input wire size_w, // word when high
   input wire [15:0] r0, // general reg zero
   input wire [15:0] r1, // general reg one
   input wire [15:0] r3, // count reg three
   input wire [15:0] a0, // address reg zero
   input wire [15:0] m_a0, // memory at address reg zero
   input wire [15:0] m_a1, // memory at address reg one
   input wire [7:0] imm, // short immediate
   input wire [15:0] sp, // selected stack pointer
   output reg [15:0] val, // operand value
   output wire ok // selector legal for size
);
   // stack pointer has no byte form
   assign ok = ~((sel == `TIE_SEL_SP) & ~size_w);

   // operand fetch mux
   always @* begin
      val = 16'h0000;
      case (sel)
         `TIE_SEL_R0: val = size_w ? r0 : {8'h00, r0[7:0]};
         `TIE_SEL_R1: val = size_w ? r1 : {8'h00, r1[7:0]};
         `TIE_SEL_R0H_R3: val = size_w ? r3 : {8'h00, r0[15:8]};
         `TIE_SEL_R1H_A0: val = size_w ? a0 : {8'h00, r1[15:8]};
         `TIE_SEL_IND_A0: val = size_w ? m_a0 : {8'h00, m_a0[7:0]};
         `TIE_SEL_IND_A1: val = size_w ? m_a1 : {8'h00, m_a1[7:0]};
         `TIE_SEL_IMM: val = size_w ? {{8{imm[7]}}, imm} : {8'h00, imm};
         `TIE_SEL_SP: val = sp;
         default: val = 16'h0000;
      endcase
   end
endmodule // tie_operand

// File: rtl/tie_exec.v
`timescale 1ns/1ps
`include "tie_defines.vh"

module tie_exec (
   input wire clk, // core clock
   input wire sys_rst, // sync reset, high
   input wire psel, // apb select
   input wire penable, // apb enable
   input wire pwrite, // apb direction
   input wire [11:0] paddr, // apb address
   input wire [31:0] pwdata, // apb write data
   output reg [31:0] prdata, // apb read data
   output wire pready, // apb ready
   output wire pslverr, // apb error
   output wire busy // instruction running
);
   localparam ST_IDLE = 2'h0;
   localparam ST_EXEC = 2'h1;
   localparam ST_STRING = 2'h2;

   reg [1:0] state;
   reg [31:0] cmd;
   reg [15:0] gr0;
   reg [15:0] gr1;
   reg [15:0] cnt3;
   reg [15:0] adr0;
   reg [15:0] adr1;
   reg [15:0] usp;
   reg [15:0] isp;
   reg [15:0] sbase;
   reg [7:0] flags;
   reg [7:0] mem_addr;
   reg err;
   reg stored;
   reg [7:0] mem [0:255];

   wire wr_en;
   wire rd_setup;
   wire [11:0] reg_addr;
   wire [3:0] op;
   wire impl;
   wire size_w;
   wire [2:0] src_sel;
   wire [2:0] dst_sel;
   wire [2:0] src2_sel;
   wire [2:0] dst_raw;
   wire [7:0] imm;
   wire zf;
   wire uf;
   wire [15:0] sp_cur;
   wire [15:0] step;
   wire [7:0] a0_nx;
   wire [7:0] a1_nx;
   wire [15:0] m_a0;
   wire [15:0] m_a1;
   wire [15:0] src_val;
   wire [15:0] src2_val;
   wire [15:0] dst_val;
   wire src_ok;
   wire src2_ok;
   wire dst_rd_ok;
   wire dst_ok;
   wire exchange_operands_ok;
   wire [15:0] store_data;

   // apb decode
   tie_apb_if u_apb (
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pready(pready),
      .pslverr(pslverr),
      .wr_en(wr_en),
      .rd_setup(rd_setup),
      .reg_addr(reg_addr)
   );

   // command fields
   assign op = cmd[`TIE_CMD_OP];
   assign impl = cmd[`TIE_CMD_IMPL];
   assign size_w = cmd[`TIE_CMD_SIZE] & ~impl;
   assign dst_raw = cmd[`TIE_CMD_DST];
   assign imm = cmd[`TIE_CMD_IMM];
   // implicit low byte of reg zero
   assign src_sel = (impl && cmd[7] == 1'b0) ? `TIE_SEL_R0 : cmd[`TIE_CMD_SRC];
   assign dst_sel = (impl && dst_raw[2] == 1'b0) ? `TIE_SEL_R0 : dst_raw;
   assign src2_sel = (impl && cmd[13] == 1'b0) ? `TIE_SEL_R0 : cmd[`TIE_CMD_SRC2];

   assign zf = flags[`TIE_FLG_Z];
   assign uf = flags[`TIE_FLG_U];
   assign sp_cur = uf ? usp : isp;
   assign step = size_w ? `TIE_STEP_WORD : `TIE_STEP_BYTE;

   // memory words, low byte first; index wraps inside 256 bytes
   assign a0_nx = adr0[7:0] + 8'h01;
   assign a1_nx = adr1[7:0] + 8'h01;
   assign m_a0 = {mem[a0_nx], mem[adr0[7:0]]};
   assign m_a1 = {mem[a1_nx], mem[adr1[7:0]]};

   // operand readers for src, second src and dest
   tie_operand u_src (
      .sel(src_sel),
      .size_w(size_w),
      .r0(gr0),
      .r1(gr1),
      .r3(cnt3),
      .a0(adr0),
      .m_a0(m_a0),
      .m_a1(m_a1),
      .imm(imm),
      .sp(sp_cur),
      .val(src_val),
      .ok(src_ok)
   );

   tie_operand u_src2 (
      .sel(src2_sel),
      .size_w(size_w),
      .r0(gr0),
      .r1(gr1),
      .r3(cnt3),
      .a0(adr0),
      .m_a0(m_a0),
      .m_a1(m_a1),
      .imm(imm),
      .sp(sp_cur),
      .val(src2_val),
      .ok(src2_ok)
   );

   tie_operand u_dst (
      .sel(dst_sel),
      .size_w(size_w),
      .r0(gr0),
      .r1(gr1),
      .r3(cnt3),
      .a0(adr0),
      .m_a0(m_a0),
      .m_a1(m_a1),
      .imm(imm),
      .sp(sp_cur),
      .val(dst_val),
      .ok(dst_rd_ok)
   );

   // an immediate can never be written
   assign dst_ok = dst_rd_ok & (dst_sel != `TIE_SEL_IMM);
   assign exchange_operands_ok = dst_ok & src_ok & (src_sel != `TIE_SEL_IMM);

   assign store_data = size_w ? gr0 : {8'h00, gr0[7:0]};

   assign busy = (state != ST_IDLE);

   // write one operand; byte forms touch only their own byte
   task store_opnd;
      input [2:0] s;
      input w;
      input [15:0] v;
      begin
         case (s)
            `TIE_SEL_R0: begin
               if (w) gr0 <= v;
               else gr0[7:0] <= v[7:0];
            end
            `TIE_SEL_R1: begin
               if (w) gr1 <= v;
               else gr1[7:0] <= v[7:0];
            end
            `TIE_SEL_R0H_R3: begin
               if (w) cnt3 <= v;
               else gr0[15:8] <= v[7:0];
            end
            `TIE_SEL_R1H_A0: begin
               if (w) adr0 <= v;
               else gr1[15:8] <= v[7:0];
            end
            `TIE_SEL_IND_A0: begin
               mem[adr0[7:0]] <= v[7:0];
               if (w) mem[a0_nx] <= v[15:8];
            end
            `TIE_SEL_IND_A1: begin
               mem[adr1[7:0]] <= v[7:0];
               if (w) mem[a1_nx] <= v[15:8];
            end
            `TIE_SEL_SP: begin
               if (uf) usp <= v;
               else isp <= v;
            end
            default: begin
            end
         endcase
      end
   endtask

   // single process owns all architectural state
   always @(posedge clk) begin
      if (sys_rst) begin
         state <= ST_IDLE;
         cmd <= `TIE_RST_CMD;
         gr0 <= `TIE_RST_WORD;
         gr1 <= `TIE_RST_WORD;
         cnt3 <= `TIE_RST_WORD;
         adr0 <= `TIE_RST_WORD;
         adr1 <= `TIE_RST_WORD;
         usp <= `TIE_RST_WORD;
         isp <= `TIE_RST_WORD;
         sbase <= `TIE_RST_WORD;
         flags <= `TIE_RST_FLAGS;
         mem_addr <= 8'h00;
         err <= 1'b0;
         stored <= 1'b0;
      end else begin
         case (state)
            // software writes only while idle, so no two writers meet
            ST_IDLE: begin
               if (wr_en) begin
                  case (reg_addr)
                     `TIE_OFF_CMD: begin
                        cmd <= pwdata;
                        err <= 1'b0;
                        stored <= 1'b0;
                        state <= ST_EXEC;
                     end
                     `TIE_OFF_GR0: gr0 <= pwdata[15:0];
                     `TIE_OFF_GR1: gr1 <= pwdata[15:0];
                     `TIE_OFF_CNT3: cnt3 <= pwdata[15:0];
                     `TIE_OFF_ADR0: adr0 <= pwdata[15:0];
                     `TIE_OFF_ADR1: adr1 <= pwdata[15:0];
                     `TIE_OFF_FLAGS: flags <= pwdata[7:0];
                     `TIE_OFF_USP: usp <= pwdata[15:0];
                     `TIE_OFF_ISP: isp <= pwdata[15:0];
                     `TIE_OFF_MADDR: mem_addr <= pwdata[7:0];
                     `TIE_OFF_MDATA: mem[mem_addr] <= pwdata[7:0];
                     `TIE_OFF_SBASE: sbase <= pwdata[15:0];
                     default: begin
                     end
                  endcase
               end
            end
            // single-step instructions; flags touched here only by the control restore
            // flags kept by stores
            ST_EXEC: begin
               state <= ST_IDLE;
               case (op)
                  `TIE_OP_STRING_OUTPUT: state <= ST_STRING;
                  `TIE_OP_STRING_STORE: state <= ST_STRING;
                  `TIE_OP_STORE_IF_NONZERO: begin
                     if (!(src_ok && dst_ok)) begin
                        err <= 1'b1;
                     end else if (!zf) begin
                        store_opnd(dst_sel, size_w, src_val);
                        stored <= 1'b1;
                     end
                  end
                  `TIE_OP_STORE_IF_ZERO: begin
                     if (!(src_ok && dst_ok)) begin
                        err <= 1'b1;
                     end else if (zf) begin
                        store_opnd(dst_sel, size_w, src_val);
                        stored <= 1'b1;
                     end
                  end
                  `TIE_OP_STORE_SEL_ZERO: begin
                     if (!(src_ok && src2_ok && dst_ok)) begin
                        err <= 1'b1;
                     end else begin
                        store_opnd(dst_sel, size_w, zf ? src_val : src2_val);
                        stored <= 1'b1;
                     end
                  end
                  `TIE_OP_EXCHANGE: begin
                     if (!exchange_operands_ok) begin
                        err <= 1'b1;
                     end else begin
                        store_opnd(src_sel, size_w, dst_val);
                        store_opnd(dst_sel, size_w, src_val);
                        stored <= 1'b1;
                     end
                  end
                  // flags change only for flag target
                  `TIE_OP_RESTORE_CTRL: begin
                     if (!src_ok || !size_w) begin
                        err <= 1'b1;
                     end else begin
                        stored <= 1'b1;
                        case (dst_raw)
                           `TIE_CTL_FLAGS: flags <= src_val[7:0];
                           `TIE_CTL_SP: store_opnd(`TIE_SEL_SP, 1'b1, src_val);
                           `TIE_CTL_SBASE: sbase <= src_val;
                           default: begin
                              err <= 1'b1;
                              stored <= 1'b0;
                           end
                        endcase
                     end
                  end
                  default: err <= 1'b1;
               endcase
            end
            // one element per clock until the count runs out
            // count down to zero
            ST_STRING: begin
               if (cnt3 == 16'h0000) begin
                  state <= ST_IDLE;
               end else begin
                  cnt3 <= cnt3 - 16'h0001;
                  stored <= 1'b1;
                  if (op == `TIE_OP_STRING_OUTPUT) begin
                     store_opnd(`TIE_SEL_IND_A1, size_w, m_a0);
                     adr0 <= adr0 + step;
                  end else begin
                     store_opnd(`TIE_SEL_IND_A1, size_w, store_data);
                     adr1 <= adr1 + step;
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // read data caught in the setup cycle, held through access
   always @(posedge clk) begin
      if (sys_rst) begin
         prdata <= 32'h00000000;
      end else if (rd_setup) begin
         case (reg_addr)
            `TIE_OFF_CMD: prdata <= cmd;
            `TIE_OFF_STATUS: prdata <= {29'h00000000, stored, err, busy};
            `TIE_OFF_GR0: prdata <= {16'h0000, gr0};
            `TIE_OFF_GR1: prdata <= {16'h0000, gr1};
            `TIE_OFF_CNT3: prdata <= {16'h0000, cnt3};
            `TIE_OFF_ADR0: prdata <= {16'h0000, adr0};
            `TIE_OFF_ADR1: prdata <= {16'h0000, adr1};
            `TIE_OFF_FLAGS: prdata <= {24'h000000, flags};
            `TIE_OFF_USP: prdata <= {16'h0000, usp};
            `TIE_OFF_ISP: prdata <= {16'h0000, isp};
            `TIE_OFF_MADDR: prdata <= {24'h000000, mem_addr};
            `TIE_OFF_MDATA: prdata <= {24'h000000, mem[mem_addr]};
            `TIE_OFF_SBASE: prdata <= {16'h0000, sbase};
            default: prdata <= 32'h00000000;
         endcase
      end
   end
endmodule // tie_exec

// File: sim/tie_exec_monitor.sv
`timescale 1ns/1ps
module tie_exec_monitor (
   input wire logic clk, // core clock
   input wire logic sys_rst, // sync reset, high
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [31:0] prdata, // apb read data
   input wire logic pready, // apb ready
   input wire logic pslverr, // apb error
   input wire logic busy // instruction running
);
   logic [15:0] cnt_start;
   logic str_op;
   logic [31:0] span;
   wire acc = psel && penable;
   wire mapped = paddr <= 12'h030 && paddr[1:0] == 2'h0;
   wire cmd_wr = acc && pwrite && !busy && paddr == 12'h000;
   // start count and busy span; a wrong stop test would stretch or shrink the span
   always @(posedge clk) begin
      if (sys_rst) begin
         cnt_start <= 16'h0000;
         str_op <= 1'b0;
         span <= 32'h0;
      end else begin
         if (acc && pwrite && !busy && paddr == 12'h010)
            cnt_start <= pwdata[15:0];
         if (cmd_wr)
            str_op <= pwdata[3:0] == 4'h1 || pwdata[3:0] == 4'h2;
         span <= busy ? span + 32'h1 : 32'h0;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_go;
      cmd_wr && pwdata[3:0] != 4'h0 && pwdata[3:0] <= 4'h7;
   endsequence
   sequence s_single_go;
      cmd_wr && pwdata[3:0] >= 4'h3 && pwdata[3:0] <= 4'h7;
   endsequence
   sequence s_one_cycle;
      busy ##1 !busy;
   endsequence
   chk_ready_high: assert property (pready) else $error("pready low");
   chk_unmapped_err: assert property (acc && !mapped |-> pslverr) else $error("no pslverr");
   chk_err_access: assert property (pslverr |-> acc) else $error("pslverr outside access");
   chk_mapped_ok: assert property (acc && mapped |-> !pslverr) else $error("pslverr on map");
   chk_err_rdata: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
      else $error("unmapped read data not zero");
   chk_cmd_busy: assert property (s_go |=> busy) else $error("busy did not rise");
   chk_single_time: assert property (s_single_go |=> s_one_cycle)
      else $error("single op not one cycle");
   chk_string_span: assert property ($fell(busy) && str_op |-> span == cnt_start + 32'h2)
      else $error("string span wrong");
   chk_idle_stays: assert property (!busy && !cmd_wr |=> !busy) else $error("busy without cmd");
endmodule // tie_exec_monitor

bind tie_exec tie_exec_monitor u_mon (.clk(clk), .sys_rst(sys_rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .busy(busy));

// File: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   wire [31:0] prdata;
   wire pready, pslverr, busy;
   int n_errors = 0, compares = 0;
   // model state, registers kept by word index
   logic [15:0] m_reg [13];
   logic [7:0] m_mem [256];
   logic m_stored, m_err, e;
   logic [31:0] q;
   int ix [9] = '{2, 3, 4, 5, 6, 7, 8, 9, 12};

   always #2.5 clk = ~clk;

   tie_exec dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .busy(busy));

   // apb master: setup, then access held until pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      compares++;
      if (g !== x) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", n, x, g);
      end
   endtask

   function automatic logic [15:0] rd(input logic [2:0] s, input logic w, input logic [7:0] i);
      logic [7:0] a;
      a = s[0] ? m_reg[6][7:0] : m_reg[5][7:0];
      case (s)
         3'h0: rd = w ? m_reg[2] : {8'h00, m_reg[2][7:0]};
         3'h1: rd = w ? m_reg[3] : {8'h00, m_reg[3][7:0]};
         3'h2: rd = w ? m_reg[4] : {8'h00, m_reg[2][15:8]};
         3'h3: rd = w ? m_reg[5] : {8'h00, m_reg[3][15:8]};
         3'h6: rd = w ? {{8{i[7]}}, i} : {8'h00, i};
         3'h7: rd = m_reg[7][7] ? m_reg[8] : m_reg[9];
         default: rd = {w ? m_mem[a + 8'h01] : 8'h00, m_mem[a]};
      endcase
   endfunction

   task automatic wr(input logic [2:0] s, input logic w, input logic [15:0] v);
      logic [7:0] a;
      a = s[0] ? m_reg[6][7:0] : m_reg[5][7:0];
      m_stored = 1'b1;
      case (s)
         3'h0: m_reg[2] = w ? v : {m_reg[2][15:8], v[7:0]};
         3'h1: m_reg[3] = w ? v : {m_reg[3][15:8], v[7:0]};
         3'h2: m_reg[w ? 4 : 2] = w ? v : {v[7:0], m_reg[2][7:0]};
         3'h3: m_reg[w ? 5 : 3] = w ? v : {v[7:0], m_reg[3][7:0]};
         3'h7: m_reg[m_reg[7][7] ? 8 : 9] = v;
         default: begin
            m_mem[a] = v[7:0];
            m_mem[a + 8'h01] = w ? v[15:8] : m_mem[a + 8'h01];
         end
      endcase
   endtask

   task automatic m_exec(input logic [31:0] c);
      logic w, z;
      logic [2:0] s, d, s2;
      logic [15:0] t, u;
      w = c[4] & ~c[14];
      z = m_reg[7][2];
      // implicit form pins register operands to the low byte
      s = (c[14] && !c[7]) ? 3'h0 : c[7:5];
      d = (c[14] && !c[10]) ? 3'h0 : c[10:8];
      s2 = (c[14] && !c[13]) ? 3'h0 : c[13:11];
      t = rd(d, w, c[23:16]);
      u = rd(s, w, c[23:16]);
      m_stored = 1'b0;
      m_err = 1'b0;
      case (c[3:0])
         4'h1, 4'h2: while (m_reg[4] != 16'h0) begin
            wr(3'h5, w, c[0] ? rd(3'h4, w, 8'h00) : m_reg[2]);
            m_reg[c[0] ? 5 : 6] = m_reg[c[0] ? 5 : 6] + (w ? 16'h0002 : 16'h0001);
            m_reg[4] = m_reg[4] - 16'h0001;
         end
         4'h3: if (!z) wr(d, w, u);
         4'h4: if (z) wr(d, w, u);
         4'h5: wr(d, w, z ? u : rd(s2, w, c[23:16]));
         // swap; memory written first so an address change cannot move it
         // two memory operands: destination written last, so it wins any overlap
         4'h6: begin
            m_err = s == 3'h6;
            if (!m_err && d[2] && !s[2]) wr(d, w, u);
            if (!m_err) wr(s, w, t);
            if (!m_err && !(d[2] && !s[2])) wr(d, w, u);
         end
         4'h7: begin
            t = rd(s, 1'b1, c[23:16]);
            m_stored = 1'b1;
            if (d == 3'h0) m_reg[7] = {8'h00, t[7:0]};
            if (d == 3'h1) m_reg[m_reg[7][7] ? 8 : 9] = t;
            if (d == 3'h2) m_reg[12] = t;
         end
      endcase
   endtask

   task automatic verify;
      for (int k = 0; k < 9; k++) begin
         apb(1'b0, {ix[k][9:0], 2'h0}, 32'h0);
         chk($sformatf("reg%0d", ix[k]), {16'h0000, m_reg[ix[k]]}, q);
      end
      for (int k = 16; k < 48; k++) begin
         apb(1'b1, 12'h028, k);
         apb(1'b0, 12'h02C, 32'h0);
         chk($sformatf("mem%0d", k), {24'h0, m_mem[k]}, q);
      end
   endtask

   task automatic set(input int i, input logic [15:0] v);
      apb(1'b1, {i[9:0], 2'h0}, {16'h0000, v});
      m_reg[i] = (i == 7) ? {8'h00, v[7:0]} : v;
   endtask

   task automatic run(input logic [31:0] c);
      apb(1'b1, 12'h000, c);
      m_exec(c);
      @(posedge clk);
      for (int k = 0; k < 80 && busy !== 1'b0; k++) @(posedge clk);
      chk("busy", 32'h0, {31'h0, busy});
      apb(1'b0, 12'h004, 32'h0);
      chk("status", {29'h0, m_stored, m_err, 1'b0}, q);
      verify();
   endtask

   function automatic logic [31:0] mk(input int op, w, s, d, s2, im, imm);
      return {8'h00, imm[7:0], 1'b0, im[0], s2[2:0], d[2:0], s[2:0], w[0], op[3:0]};
   endfunction

   task automatic final_report;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // watchdog, several times the expected run of about 13k cycles
   initial begin
      #400000;
      n_errors++;
      final_report();
   end

   initial begin
      logic [31:0] c;
      void'($urandom(75557));
      foreach (m_reg[k]) m_reg[k] = 16'h0000;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      // memory is not cleared by reset, so fill all of it first
      for (int k = 0; k < 256; k++) begin
         c = $urandom;
         apb(1'b1, 12'h028, k);
         apb(1'b1, 12'h02C, c);
         m_mem[k] = c[7:0];
      end
      verify();
      // status is read only; unaligned and out of range are refused
      apb(1'b1, 12'h004, 32'hFFFFFFFF);
      apb(1'b0, 12'h004, 32'h0);
      chk("status", 32'h0, q);
      apb(1'b0, 12'h034, 32'h0);
      chk("pslverr", 32'h1, {31'h0, e});
      apb(1'b0, 12'h006, 32'h0);
      chk("pslverr", 32'h1, {31'h0, e});
      chk("unaligned", 32'h0, q);
      for (int k = 2; k < 7; k++) set(k, $urandom);
      // conditional stores with both zero flag values
      for (int op = 3; op < 6; op++) begin
         for (int r = 0; r < 8; r++) begin
            c = $urandom;
            set(7, {8'h00, c[31:27], r[0], c[25:24]});
            run(mk(op, c[0], c[3:1] % 7, c[6:4] % 6, c[9:7] % 7, c[10], c[23:16]));
         end
      end
      // exchanges, then one refused for an immediate operand
      for (int r = 0; r < 10; r++) begin
         c = $urandom;
         run(mk(6, c[0], c[3:1] % 7, c[6:4] % 6, 0, c[10], c[23:16]));
      end
      run(mk(6, 1, 6, 0, 0, 0, 8'h5A));
      // restores cycle through flags, stack pointer and base with both stack selects
      for (int r = 0; r < 6; r++) begin
         c = $urandom;
         run(mk(7, 1, 6, r % 3, 0, 0, {r[0], c[6:0]}));
      end
      // stack pointer read back as a source under the select flag left above
      run(mk(5, 1, 7, 1, 7, 0, 0));
      // strings in both sizes, with a zero count among them
      for (int r = 0; r < 8; r++) begin
         set(5, 16'h0010);
         set(6, 16'h0020);
         set(4, r[2] ? 16'h0003 : 16'h0000);
         run(mk(1 + r[0], r[1], 0, 0, 0, 0, 0));
      end
      final_report();
   end
endmodule // tb_top
